/* File: rtl/cem_pkg.sv */
// Purpose: shared constants of the CSI-2 receive fault monitor
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes: byte address of a register is four times its index

// ==========================================================
// register map
package cem_pkg;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int BYTE_W = 8;
  localparam logic [IDX_W-1:0] IDX_TALLY = 8'h5c;
  localparam logic [IDX_W-1:0] IDX_PKT_FLAGS = 8'h5d;
  localparam logic [IDX_W-1:0] IDX_LANES01 = 8'h5e;
  localparam logic [IDX_W-1:0] IDX_LANES23 = 8'h5f;
  localparam logic [IDX_W-1:0] IDX_CLK_LANE = 8'h60;
  localparam logic [IDX_W-1:0] IDX_HDR_CHAN = 8'h61;
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 8'h62;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 8'h63;
  localparam logic [IDX_W-1:0] IDX_HDR_ECC = 8'h64;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 8'h80;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 8'h81;

  // ==========================================================
  // reset values and limits
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] TALLY_MAX = 8'hff;
  localparam logic [BYTE_W-1:0] TALLY_STEP = 8'h01;

  // ==========================================================
  // field positions
  localparam int PKT_W = 4;
  localparam int BIT_SHORT_LINE = 3;
  localparam int BIT_PAYLOAD_SUM = 2;
  localparam int BIT_HDR_DOUBLE = 1;
  localparam int BIT_HDR_SINGLE = 0;
  localparam int LANES = 4;
  localparam int NIB_SYNC_SINGLE = 3;
  localparam int NIB_SYNC_MULTI = 2;
  localparam int NIB_HS_REQ = 1;
  localparam int NIB_RSVD = 0;
  localparam int ODD_LANE_SHIFT = 4;
  localparam int BIT_CLOCK_LANE_CTL = 1;
  localparam int BIT_LINE_CHANGE = 7;
  localparam int VC_W = 2;
  localparam int DT_W = 6;
  localparam int WC_W = 16;
  localparam int ECC_W = 6;

  // ==========================================================
  // event status layout
  localparam int EV_W = 5;
  localparam int EV_TALLY = 0;
  localparam int EV_PACKET = 1;
  localparam int EV_LANE = 2;
  localparam int EV_HEADER = 3;
  localparam int EV_LINE_CHANGE = 4;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : cem_pkg

/* File: rtl/cem_sync.sv */
// Purpose: three-stage synchroniser for pins from another domain
// Assumes: input bits are held for several hclk periods
// Notes: a change passes once stages two and three agree

// ==========================================================
// synchroniser
module cem_sync #(
  parameter int WIDTH = 1
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic [WIDTH-1:0] async_in, // raw pins
  output logic [WIDTH-1:0] stable_out // filtered levels
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      stable_out <= (stable_out & ~agree) | (stage3 & agree);
    end
  end
endmodule : cem_sync

/* File: rtl/cem_rc_flag.sv */
// Purpose: sticky flags cleared by a selective clear strobe
// Assumes: set and clear are single-cycle pulses
// Notes: a set in the clearing cycle wins

// ==========================================================
// sticky flags
module cem_rc_flag #(
  parameter int WIDTH = 1
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic [WIDTH-1:0] set, // event pulses
  input wire logic clr, // clear strobe
  input wire logic [WIDTH-1:0] clr_bits, // bits to clear
  output logic [WIDTH-1:0] flags // sticky state
);
  logic [WIDTH-1:0] next_flags;

  assign next_flags = (flags & ~({WIDTH{clr}} & clr_bits)) | set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : cem_rc_flag

/* File: rtl/cem_monitor.sv */
// Purpose: CSI-2 receive fault monitor with AHB-Lite register bank
// Assumes: receiver fault and header signals change on link clock falling edges
// Notes: link pins are sampled on rising edges of the synchronised link clock
//
// How it works
// [R1] an 8-bit tally counts errored packets since its last read, resets to zero, read clears it
// [R2] bit 3 of the packet fault flags marks a line shorter than its header count, read clears it
// [R3] bit 2 of the packet fault flags marks a payload checksum fault, read clears it
// [R4] bit 1 of the packet fault flags marks a two-bit header error, read clears it
// [R5] bit 0 of the packet fault flags marks a single-bit header error, read clears it
// [R6] each data lane shows a single-bit sync fault in bit 3 (even lane) or bit 7 (odd lane)
// [R7] each data lane shows a multi-bit sync fault in bit 2 (even lane) or bit 6 (odd lane)
// [R8] each data lane shows a request control fault in bit 1 (even lane) or bit 5 (odd lane)
// [R9] lanes 0/1 share one register and lanes 2/3 the next, odd lane high, bits 4 and 0 zero
// [R10] the clock lane control fault sits in bit 1 of its register, other bits zero
// [R11] the header virtual channel is captured into bits 7:6 of the header register
// [R12] the header data type is captured into bits 5:0 of that register, reset zero
// [R13] the header word count is captured, low byte in one register, high byte in the next
// [R14] the header ECC field is captured into bits 5:0 of the ECC register
// [R15] bit 7 of the ECC register shows a line length change within the frame
// [R16] the tally saturates at its maximum and header fields hold the latest long packet
// [R17] only a completed read clears (event status bits: a completed write of ones), and an event in the clearing cycle stays recorded
//
// Register access over AHB-Lite is this design's own decision.

// ==========================================================
// top module
module cem_monitor (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [cem_pkg::DATA_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write access
  input wire logic [2:0] hsize, // transfer size
  input wire logic [cem_pkg::DATA_W-1:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [cem_pkg::DATA_W-1:0] hrdata, // read data
  output logic irq, // interrupt, level
  input wire logic link_clk, // link clock pin
  input wire logic pkt_err, // errored packet
  input wire logic short_line_flag, // line shorter than count
  input wire logic payload_sum_fault, // checksum fault
  input wire logic header_double_fault, // two-bit header error
  input wire logic header_single_fault, // one-bit header error
  input wire logic [cem_pkg::LANES-1:0] sync_single_fault, // per lane
  input wire logic [cem_pkg::LANES-1:0] sync_multi_fault, // per lane
  input wire logic [cem_pkg::LANES-1:0] hs_request_control_fault, // per lane
  input wire logic clock_lane_control_fault, // clock lane fault
  input wire logic hdr_valid, // long packet header seen
  input wire logic [cem_pkg::VC_W-1:0] hdr_channel, // virtual channel
  input wire logic [cem_pkg::DT_W-1:0] hdr_type, // data type
  input wire logic [cem_pkg::WC_W-1:0] hdr_count, // word count
  input wire logic [cem_pkg::ECC_W-1:0] hdr_ecc, // header ECC
  input wire logic line_length_change // length changed in frame
);
  import cem_pkg::*;

  // ==========================================================
  // link sampling
  localparam int LINK_W = 6 + 3 * LANES + 2 + VC_W + DT_W + WC_W + ECC_W + 1;

  logic [LINK_W-1:0] link_raw;
  logic [LINK_W-1:0] link_q;
  logic s_clk;
  logic s_pkt_err;
  logic s_short;
  logic s_sum;
  logic s_double;
  logic s_single;
  logic [LANES-1:0] s_sync_single;
  logic [LANES-1:0] s_sync_multi;
  logic [LANES-1:0] s_hs_req;
  logic s_clk_lane;
  logic s_hdr_valid;
  logic [VC_W-1:0] s_chan;
  logic [DT_W-1:0] s_type;
  logic [WC_W-1:0] s_count;
  logic [ECC_W-1:0] s_ecc;
  logic s_line_change;
  logic clk_seen;
  logic link_edge;

  assign link_raw = {link_clk, pkt_err, short_line_flag, payload_sum_fault,
    header_double_fault, header_single_fault, sync_single_fault, sync_multi_fault,
    hs_request_control_fault, clock_lane_control_fault, hdr_valid, hdr_channel,
    hdr_type, hdr_count, hdr_ecc, line_length_change};

  cem_sync #(.WIDTH(LINK_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(link_raw),
    .stable_out(link_q)
  );

  assign {s_clk, s_pkt_err, s_short, s_sum, s_double, s_single, s_sync_single,
    s_sync_multi, s_hs_req, s_clk_lane, s_hdr_valid, s_chan, s_type, s_count,
    s_ecc, s_line_change} = link_q;

  // rising edge of the filtered link clock
  assign link_edge = s_clk & ~clk_seen;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_seen <= 1'b0;
    end else begin
      clk_seen <= s_clk;
    end
  end

  // ==========================================================
  // bus slave
  logic addr_phase;
  logic addr_mapped;
  logic [IDX_W-1:0] addr_idx;
  logic dp_valid;
  logic dp_write;
  logic [IDX_W-1:0] dp_idx;
  logic rd_done;
  logic wr_done;
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] rd_snap;
  logic [DATA_W-1:0] rd_value;

  assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign addr_idx = haddr[IDX_W+1:2];
  assign addr_mapped = (haddr[DATA_W-1:IDX_W+2] == '0) & (haddr[1:0] == 2'h0);
  assign rd_done = dp_valid & ~dp_write & hready;
  assign wr_done = dp_valid & dp_write & hready;
  assign rd_snap = hrdata[BYTE_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= '0;
    end else if (hready) begin
      dp_valid <= addr_phase & addr_mapped;
      dp_write <= hwrite;
      dp_idx <= addr_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // ==========================================================
  // errored packet tally
  logic [BYTE_W-1:0] tally;
  logic [BYTE_W-1:0] tally_base;
  logic [BYTE_W-1:0] next_tally;
  logic tally_inc;
  logic clr_tally;

  assign tally_inc = link_edge & s_pkt_err;
  assign clr_tally = rd_done & (dp_idx == IDX_TALLY); // R17
  // remove only what was read, so counts in the data phase survive
  assign tally_base = clr_tally ? tally - rd_snap : tally; // R1
  assign next_tally = (tally_inc && tally_base != TALLY_MAX) ?
    tally_base + TALLY_STEP : tally_base; // R16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tally <= REG_RESET;
    end else begin
      tally <= next_tally;
    end
  end

  // ==========================================================
  // packet fault flags
  logic [PKT_W-1:0] pkt_set;
  logic [PKT_W-1:0] pkt_flags;
  logic clr_pkt;

  assign pkt_set[BIT_SHORT_LINE] = link_edge & s_short; // R2
  assign pkt_set[BIT_PAYLOAD_SUM] = link_edge & s_sum; // R3
  assign pkt_set[BIT_HDR_DOUBLE] = link_edge & s_double; // R4
  assign pkt_set[BIT_HDR_SINGLE] = link_edge & s_single; // R5
  assign clr_pkt = rd_done & (dp_idx == IDX_PKT_FLAGS); // R17

  cem_rc_flag #(.WIDTH(PKT_W)) u_pkt_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(pkt_set),
    .clr(clr_pkt),
    .clr_bits(rd_snap[PKT_W-1:0]),
    .flags(pkt_flags)
  );

  // ==========================================================
  // lane faults
  logic [2*BYTE_W-1:0] lane_bits;
  logic [BYTE_W-1:0] lanes01;
  logic [BYTE_W-1:0] lanes23;
  logic clk_lane;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    localparam int BASE = BYTE_W * (l / 2) + ODD_LANE_SHIFT * (l % 2);
    assign lane_bits[BASE+NIB_SYNC_SINGLE] = s_sync_single[l]; // R6
    assign lane_bits[BASE+NIB_SYNC_MULTI] = s_sync_multi[l]; // R7
    assign lane_bits[BASE+NIB_HS_REQ] = s_hs_req[l]; // R8
    assign lane_bits[BASE+NIB_RSVD] = 1'b0; // R9
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lanes01 <= REG_RESET;
      lanes23 <= REG_RESET;
      clk_lane <= 1'b0;
    end else if (link_edge) begin
      {lanes23, lanes01} <= lane_bits; // R9
      clk_lane <= s_clk_lane; // R10
    end
  end

  // ==========================================================
  // header capture
  logic hdr_take;
  logic [BYTE_W-1:0] hdr_chan_type;
  logic [WC_W-1:0] hdr_words;
  logic [ECC_W-1:0] hdr_ecc_q;
  logic line_change;

  assign hdr_take = link_edge & s_hdr_valid; // R16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdr_chan_type <= REG_RESET;
      hdr_words <= '0;
      hdr_ecc_q <= '0;
    end else if (hdr_take) begin
      hdr_chan_type <= {s_chan, s_type}; // R11 R12
      hdr_words <= s_count; // R13
      hdr_ecc_q <= s_ecc; // R14
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_change <= 1'b0;
    end else if (link_edge) begin
      line_change <= s_line_change; // R15
    end
  end

  // ==========================================================
  // events and interrupt
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] evt_status;
  logic [EV_W-1:0] evt_mask;
  logic clr_status;

  assign ev_set[EV_TALLY] = tally_inc;
  assign ev_set[EV_PACKET] = |pkt_set;
  assign ev_set[EV_LANE] = link_edge & ((|lane_bits) | s_clk_lane);
  assign ev_set[EV_HEADER] = hdr_take;
  assign ev_set[EV_LINE_CHANGE] = link_edge & s_line_change & ~line_change;
  assign clr_status = wr_done & (dp_idx == IDX_EVT_STATUS);

  cem_rc_flag #(.WIDTH(EV_W)) u_evt_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(ev_set),
    .clr(clr_status),
    .clr_bits(hwdata[EV_W-1:0]),
    .flags(evt_status)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_mask <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_done && dp_idx == IDX_EVT_MASK) begin
        evt_mask <= hwdata[EV_W-1:0];
      end
      irq <= |(evt_status & evt_mask);
    end
  end

  // ==========================================================
  // read selection
  assign rd_byte =
    (!addr_mapped) ? REG_RESET :
    (addr_idx == IDX_TALLY) ? tally : // R1
    (addr_idx == IDX_PKT_FLAGS) ? {{(BYTE_W-PKT_W){1'b0}}, pkt_flags} :
    (addr_idx == IDX_LANES01) ? lanes01 :
    (addr_idx == IDX_LANES23) ? lanes23 :
    (addr_idx == IDX_CLK_LANE) ? BYTE_W'({7'h00, clk_lane} << BIT_CLOCK_LANE_CTL) : // R10
    (addr_idx == IDX_HDR_CHAN) ? hdr_chan_type :
    (addr_idx == IDX_COUNT_LOW) ? hdr_words[BYTE_W-1:0] : // R13
    (addr_idx == IDX_COUNT_HIGH) ? hdr_words[WC_W-1:BYTE_W] : // R13
    (addr_idx == IDX_HDR_ECC) ? {line_change, 1'b0, hdr_ecc_q} : // R14 R15
    (addr_idx == IDX_EVT_STATUS) ? {{(BYTE_W-EV_W){1'b0}}, evt_status} :
    (addr_idx == IDX_EVT_MASK) ? {{(BYTE_W-EV_W){1'b0}}, evt_mask} :
    REG_RESET;
  assign rd_value = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tally_counts_event: assert property ( // R1
    tally_inc && !clr_tally && tally != TALLY_MAX |=> tally == $past(tally) + TALLY_STEP)
    else $error("tally did not count an errored packet");
  a_tally_holds_max: assert property ( // R16
    tally == TALLY_MAX && !clr_tally |=> tally == TALLY_MAX)
    else $error("tally wrapped past its maximum");
  a_tally_read_keeps: assert property ( // R17
    clr_tally && tally_inc |=> tally == $past(tally) - $past(rd_snap) + TALLY_STEP)
    else $error("packet counted during clear was lost");
  a_short_line_set: assert property ( // R2
    link_edge && s_short |=> pkt_flags[BIT_SHORT_LINE])
    else $error("short line flag not set");
  a_sum_fault_set: assert property ( // R3
    link_edge && s_sum |=> pkt_flags[BIT_PAYLOAD_SUM])
    else $error("checksum flag not set");
  a_header_double_set: assert property ( // R4
    link_edge && s_double |=> pkt_flags[BIT_HDR_DOUBLE])
    else $error("double header flag not set");
  a_header_single_set: assert property ( // R5
    link_edge && s_single |=> pkt_flags[BIT_HDR_SINGLE])
    else $error("single header flag not set");
  a_flags_read_clear: assert property ( // R17
    clr_pkt && pkt_set == '0 |=> (pkt_flags & $past(rd_snap[PKT_W-1:0])) == '0)
    else $error("read did not clear the packet flags");
  a_odd_sync_single: assert property ( // R6
    link_edge && s_sync_single[1] |=> lanes01[NIB_SYNC_SINGLE+ODD_LANE_SHIFT])
    else $error("lane 1 single sync fault misplaced");
  a_even_sync_multi: assert property ( // R7
    link_edge && s_sync_multi[2] |=> lanes23[NIB_SYNC_MULTI])
    else $error("lane 2 multi sync fault misplaced");
  a_odd_hs_request: assert property ( // R8
    link_edge && s_hs_req[3] |=> lanes23[NIB_HS_REQ+ODD_LANE_SHIFT])
    else $error("lane 3 request fault misplaced");
  a_lane_reserved_zero: assert property ( // R9
    lanes01[NIB_RSVD] == 1'b0 && lanes23[NIB_RSVD+ODD_LANE_SHIFT] == 1'b0)
    else $error("reserved lane bit set");
  a_clock_lane_track: assert property ( // R10
    link_edge |=> clk_lane == $past(s_clk_lane))
    else $error("clock lane fault not tracked");
  a_header_capture: assert property ( // R11
    hdr_take |=> hdr_chan_type == {$past(s_chan), $past(s_type)} && hdr_words == $past(s_count))
    else $error("header fields not captured");
  a_irq_follows: assert property (
    (evt_status & evt_mask) != '0 |=> irq)
    else $error("interrupt missing for unmasked event");

  c_tally_cleared: cover property (clr_tally && tally != REG_RESET);
  c_tally_saturated: cover property (tally == TALLY_MAX);
  c_header_taken: cover property (hdr_take);
  c_irq_raised: cover property (!irq ##1 irq);
endmodule : cem_monitor

/* File: tb/cem_sensor_model.sv */
// Purpose: behavioural sensor side driving the link pins of the monitor
// Assumes: link clock stands low between frames, one sample per frame
// Notes: released lines show the inverse of the last value, except the header strobe, which drops low

// ==========================================================
// sensor model
module cem_sensor_model (
  output logic link_clk, // link clock
  output logic pkt_err, // errored packet
  output logic short_line_flag, // short line
  output logic payload_sum_fault, // checksum fault
  output logic header_double_fault, // two-bit header
  output logic header_single_fault, // one-bit header
  output logic [3:0] sync_single_fault, // per lane
  output logic [3:0] sync_multi_fault, // per lane
  output logic [3:0] hs_request_control_fault, // per lane
  output logic clock_lane_control_fault, // clock lane
  output logic hdr_valid, // header present
  output logic [1:0] hdr_channel, // channel
  output logic [5:0] hdr_type, // data type
  output logic [15:0] hdr_count, // word count
  output logic [5:0] hdr_ecc, // header ecc
  output logic line_length_change // length change
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_clk = 1'b0;
    put(50'h0);
  end

  task automatic put(input logic [49:0] v);
    {pkt_err, short_line_flag, payload_sum_fault, header_double_fault,
     header_single_fault, sync_single_fault, sync_multi_fault,
     hs_request_control_fault, clock_lane_control_fault, hdr_valid,
     hdr_channel, hdr_type, hdr_count, hdr_ecc, line_length_change} = v;
  endtask : put

  // one frame: data set while low, one rise, then lines released
  task automatic send(input logic [49:0] v);
    #3;
    put(v);
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
    // header strobe drops low, the other lines show the inverse
    #40 put(~v & ~50'h80000000);
  endtask : send
endmodule : cem_sensor_model

/* File: tb/cem_monitor_test.sv */
// Purpose: self-checking bench of the CSI-2 receive fault monitor
// Assumes: one AHB-Lite slave, hready looped from hreadyout
// Notes: an integer model is compared at every register read

// ==========================================================
// bench
module cem_monitor_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cem_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] haddr, hwdata, hrdata;
  logic link_clk, pkt_err, short_line_flag, payload_sum_fault;
  logic header_double_fault, header_single_fault, clock_lane_control_fault;
  logic hdr_valid, line_length_change;
  logic [3:0] sync_single_fault, sync_multi_fault, hs_request_control_fault;
  logic [1:0] hdr_channel;
  logic [5:0] hdr_type, hdr_ecc;
  logic [15:0] hdr_count, m_wc;
  logic [7:0] m_tally, m_pf, m_l01, m_l23, m_ck, m_vt, m_ecc, m_st, m_mask;
  int error_cnt = 0;
  int checks = 0;

  cem_monitor u_cem_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
    .link_clk, .pkt_err, .short_line_flag, .payload_sum_fault,
    .header_double_fault, .header_single_fault, .sync_single_fault,
    .sync_multi_fault, .hs_request_control_fault, .clock_lane_control_fault,
    .hdr_valid, .hdr_channel, .hdr_type, .hdr_count, .hdr_ecc,
    .line_length_change);

  cem_sensor_model u_cem_sensor_model (.link_clk, .pkt_err, .short_line_flag,
    .payload_sum_fault, .header_double_fault, .header_single_fault,
    .sync_single_fault, .sync_multi_fault, .hs_request_control_fault,
    .clock_lane_control_fault, .hdr_valid, .hdr_channel, .hdr_type,
    .hdr_count, .hdr_ecc, .line_length_change);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ==========================================================
  // checks and bus cycles
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ad

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask : rd

  task automatic check_all;
    rd(ad(IDX_TALLY), m_tally);
    m_tally = 8'h0;
    rd(ad(IDX_PKT_FLAGS), m_pf);
    m_pf = 8'h0;
    rd(ad(IDX_LANES01), m_l01);
    rd(ad(IDX_LANES23), m_l23);
    rd(ad(IDX_CLK_LANE), m_ck);
    rd(ad(IDX_HDR_CHAN), m_vt);
    rd(ad(IDX_COUNT_LOW), m_wc[7:0]);
    rd(ad(IDX_COUNT_HIGH), m_wc[15:8]);
    rd(ad(IDX_HDR_ECC), m_ecc);
    rd(ad(IDX_EVT_MASK), m_mask);
    rd(ad(IDX_EVT_STATUS), m_st);
  endtask : check_all

  // ==========================================================
  // reference model of one link sample
  task automatic frame(input logic [49:0] v);
    u_cem_sensor_model.send(v);
    if (v[49]) begin
      if (m_tally !== 8'hff) m_tally = m_tally + 8'h1;
      m_st[EV_TALLY] = 1'b1;
    end
    m_pf = m_pf | {4'h0, v[48:45]};
    if (|v[48:45]) m_st[EV_PACKET] = 1'b1;
    m_l01 = {v[42], v[38], v[34], 1'b0, v[41], v[37], v[33], 1'b0};
    m_l23 = {v[44], v[40], v[36], 1'b0, v[43], v[39], v[35], 1'b0};
    m_ck = {6'h0, v[32], 1'b0};
    if (|v[44:32]) m_st[EV_LANE] = 1'b1;
    if (v[31]) begin
      m_vt = v[30:23];
      m_wc = v[22:7];
      m_ecc[5:0] = v[6:1];
      m_st[EV_HEADER] = 1'b1;
    end
    if (v[0] && !m_ecc[7]) m_st[EV_LINE_CHANGE] = 1'b1;
    m_ecc[7] = v[0];
    repeat (10) @(posedge hclk);
    chk({31'h0, irq}, {31'h0, |(m_st & m_mask)});
  endtask : frame

  task automatic do_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    {m_tally, m_pf, m_l01, m_l23, m_ck, m_vt, m_ecc, m_st, m_mask, m_wc} = 88'h0;
  endtask : do_reset

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [49:0] v;
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    hsize = 3'h2;
    hresetn = 1'b0;
    r = $urandom(32'hbf639466);
    @(posedge hclk);
    do_reset(10);
    check_all;
    xfer(1'b1, ad(IDX_LANES01), 32'hff, r);
    xfer(1'b1, ad(IDX_TALLY), 32'hff, r);
    rd(32'h400, 8'h0);
    rd(32'h3fc, 8'h0);
    for (int i = 0; i < 24; i++) begin
      v = 50'({$urandom(), $urandom()});
      // header absent: captured fields must hold
      if (i % 4 == 0) v[31] = 1'b0;
      frame(v);
      d = $urandom();
      m_mask = {3'h0, d[4:0]};
      xfer(1'b1, ad(IDX_EVT_MASK), {27'h0, d[4:0]}, r);
      check_all;
      xfer(1'b1, ad(IDX_EVT_STATUS), {27'h0, d[9:5]}, r);
      m_st = m_st & ~{3'h0, d[9:5]};
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, {31'h0, |(m_st & m_mask)});
      if (i == 12) begin
        do_reset(3);
        check_all;
      end
    end
    for (int i = 0; i < 258; i++) frame({1'b1, 49'h0});
    check_all;
    print_verdict;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    print_verdict;
  end
endmodule : cem_monitor_test
